// ### core/flash_ctl_pkg.sv
// Package of constants for the parallel flash status controller
package flash_ctl_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] ADDR_OFS   = 8'h04;
  localparam logic [7:0] WDATA_OFS  = 8'h08;
  localparam logic [7:0] RDATA_OFS  = 8'h0C;
  localparam logic [7:0] STAT_OFS   = 8'h10;
  localparam logic [7:0] ACCUM_OFS  = 8'h14;

  // ****************************************
  // Operation codes in the command register
  // ****************************************
  localparam logic [2:0] OP_WRITE   = 3'h1;
  localparam logic [2:0] OP_READ    = 3'h2;
  localparam logic [2:0] OP_STATUS  = 3'h3;
  localparam logic [2:0] OP_POLL    = 3'h4;
  localparam logic [2:0] OP_CLEAR   = 3'h5;
  localparam logic [2:0] OP_ARRAY   = 3'h6;
  localparam logic [2:0] OP_PINRST  = 3'h7;

  // ****************************************
  // Flash command codes on the low data byte
  // ****************************************
  localparam logic [7:0] FC_READ_STATUS  = 8'h70;
  localparam logic [7:0] FC_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] FC_READ_ARRAY   = 8'hFF;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int MACHINE_READY_BIT   = 7;
  localparam int ERASE_SUSP_BIT      = 6;
  localparam int ERASE_ERR_BIT       = 5;
  localparam int PROG_ERR_BIT        = 4;
  localparam int SUPPLY_LOW_BIT      = 3;
  localparam int PROG_SUSP_BIT       = 2;
  localparam int LOCKED_SECTOR_BIT   = 1;
  localparam logic [7:0] STATUS_USE_MASK = 8'hFE;
  localparam logic [7:0] ERROR_MASK      = 8'h3A;

  // ****************************************
  // Pin timing, in ns, and cycle counts at 8 ns
  // ****************************************
  localparam int CLK_NS        = 8;
  localparam int STROBE_NS     = 70;
  localparam int SETUP_NS      = 30;
  localparam int GAP_NS        = 30;
  localparam int RESET_NS      = 500;
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SETUP_CYC  = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] GAP_CYC    = 8'((GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RESET_CYC  = 8'((RESET_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

endpackage

// ### core/flash_status_ctl.sv
// Host controller that drives a parallel flash and reads its status
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// ****************************************
// Notes on behaviour
// (RL1) After read-status command, device returns status on every read until other command.
// (RL2) Host writes read-array command to get array data back after status.
// (RL3) Status reads carry status on low byte, zeros on upper byte.
// (RL4) Device latches status snapshot on the later enable falling edge.
// (RL5) Host toggles chip or output enable between successive status reads.
// (RL6) Bit 7 is ready when 1, busy when 0; other bits report success.
// (RL7) Bit 6 marks erase suspended; set with bit 7, held until resume.
// (RL8) Bit 2 marks program suspended; set with bit 7, held until resume.
// (RL9) Bit 5 set when sector erase fails verify.
// (RL10) Bit 4 set when word program fails.
// (RL11) Bit 3 set and operation aborted when programming supply too low.
// (RL12) Bit 1 set and operation aborted on locked sector target.
// (RL13) Bit 0 reserved; host masks it when evaluating status.
// (RL14) Bits 1, 3, 4, 5 together signal a command sequence error.
// (RL15) Device may clear only bits 2, 6 and 7 itself; the model's machine updates can clear bit 0 as well.
// (RL16) Error bits accumulate until clear-status command is written.
// (RL17) Host issues clear-status before each new program or erase.
// (RL18) After clear-status, host writes read-array before expecting array data.
// (RL19) Hardware reset clears the status register.
// (RL20) Writes pulse write strobe low with chip enable low, output enable high.
// (RL21) During programming only status, suspend and resume commands are accepted.
// (RL22) Reset low halts operation, floats outputs; high returns to read-array.
// ****************************************
module flash_status_ctl (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Flash pins
  output logic      [20:0] FA,
  output logic             FCE_N,
  output logic             FOE_N,
  output logic             FWE_N,
  output logic             FRESET_N,
  input  wire logic [15:0] FDQ_I,
  output logic      [15:0] FDQ_O,
  output logic             FDQ_OE
);

  // ****************************************
  // Types and state
  // ****************************************
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_GAP, S_RESET} seq_e;

  seq_e        state_q;
  logic [7:0]  cnt_q;
  logic [2:0]  op_q;
  logic        busy_q;
  logic        is_write_q;
  logic [15:0] flash_dat_q;
  logic [20:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [7:0]  status_q;
  logic [7:0]  accum_q;
  logic        stat_mode_q;
  logic        seq_err_q;
  logic        done_q;
  logic [15:0] dq_m1_q;
  logic [15:0] dq_m2_q;
  logic [15:0] dq_m3_q;
  logic [15:0] dq_val_q;
  logic        ap_wr_q;
  logic        ap_rd_q;
  logic [7:0]  ap_ofs_q;
  logic        ap_valid;
  logic        go;
  logic [2:0]  go_op;

  // Strip reserved bit before evaluating a status value
  function automatic logic [7:0] usable(input logic [7:0] s);
    return s & flash_ctl_pkg::STATUS_USE_MASK; // RL13
  endfunction

  // ****************************************
  // AHB-Lite slave, zero wait states; a start written while a sequence is busy is dropped
  // ****************************************
  assign ap_valid = HSEL && HREADY && HTRANS[1];
  assign go       = ap_wr_q && (ap_ofs_q == flash_ctl_pkg::CMD_OFS) && !busy_q;
  assign go_op    = HWDATA[2:0];

  // Address phase capture
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ap_wr_q  <= 1'b0;
      ap_rd_q  <= 1'b0;
      ap_ofs_q <= 8'h00;
    end else if (HREADYOUT) begin
      ap_wr_q  <= ap_valid && HWRITE;
      ap_rd_q  <= ap_valid && !HWRITE;
      ap_ofs_q <= HADDR[7:0];
    end
  end

  // Response is always OKAY; unmapped offsets read zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      HRDATA    <= flash_ctl_pkg::WORD_RST;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRDATA    <= flash_ctl_pkg::WORD_RST;
      if (ap_valid && !HWRITE) begin
        unique case (HADDR[7:0])
          flash_ctl_pkg::CMD_OFS:   HRDATA <= {29'h0, op_q};
          flash_ctl_pkg::ADDR_OFS:  HRDATA <= {11'h0, addr_q};
          flash_ctl_pkg::WDATA_OFS: HRDATA <= {16'h0, wdata_q};
          flash_ctl_pkg::RDATA_OFS: HRDATA <= {16'h0, rdata_q};
          flash_ctl_pkg::STAT_OFS:  HRDATA <= {20'h0, seq_err_q, stat_mode_q, done_q, busy_q, status_q};
          flash_ctl_pkg::ACCUM_OFS: HRDATA <= {24'h0, accum_q};
          default:                  HRDATA <= flash_ctl_pkg::WORD_RST;
        endcase
      end
    end
  end

  // Address and write data registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      addr_q  <= 21'h0;
      wdata_q <= 16'h0;
    end else if (ap_wr_q) begin
      if (ap_ofs_q == flash_ctl_pkg::ADDR_OFS) addr_q <= HWDATA[20:0];
      if (ap_ofs_q == flash_ctl_pkg::WDATA_OFS) wdata_q <= HWDATA[15:0];
    end
  end

  // ****************************************
  // Data input synchroniser, a change counts once stages two and three agree
  // ****************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dq_m1_q  <= 16'h0;
      dq_m2_q  <= 16'h0;
      dq_m3_q  <= 16'h0;
      dq_val_q <= 16'h0;
    end else begin
      dq_m1_q <= FDQ_I;
      dq_m2_q <= dq_m1_q;
      dq_m3_q <= dq_m2_q;
      if (dq_m2_q == dq_m3_q) dq_val_q <= dq_m3_q;
    end
  end

  // ****************************************
  // Bus cycle sequencer
  // ****************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q     <= S_IDLE;
      cnt_q       <= 8'h00;
      op_q        <= 3'h0;
      busy_q      <= 1'b0;
      is_write_q  <= 1'b0;
      flash_dat_q <= 16'h0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (go) begin
            op_q   <= go_op;
            busy_q <= 1'b1;
            cnt_q  <= flash_ctl_pkg::SETUP_CYC;
            unique case (go_op)
              flash_ctl_pkg::OP_WRITE:  begin is_write_q <= 1'b1; flash_dat_q <= wdata_q; end
              flash_ctl_pkg::OP_STATUS: begin is_write_q <= 1'b1; flash_dat_q <= {8'h00, flash_ctl_pkg::FC_READ_STATUS}; end
              flash_ctl_pkg::OP_CLEAR:  begin is_write_q <= 1'b1; flash_dat_q <= {8'h00, flash_ctl_pkg::FC_CLEAR_STATUS}; end
              flash_ctl_pkg::OP_ARRAY:  begin is_write_q <= 1'b1; flash_dat_q <= {8'h00, flash_ctl_pkg::FC_READ_ARRAY}; end
              default:                  begin is_write_q <= 1'b0; flash_dat_q <= flash_dat_q; end
            endcase
            state_q <= (go_op == flash_ctl_pkg::OP_PINRST) ? S_RESET : S_SETUP;
            if (go_op == flash_ctl_pkg::OP_PINRST) cnt_q <= flash_ctl_pkg::RESET_CYC;
          end
        end
        S_SETUP: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            state_q <= S_STROBE;
            cnt_q   <= flash_ctl_pkg::STROBE_CYC;
          end
        end
        S_STROBE: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          state_q <= S_GAP;
          cnt_q   <= flash_ctl_pkg::GAP_CYC;
        end
        S_GAP, S_RESET: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            state_q <= S_IDLE;
            busy_q  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Pin drive: writes strobe the write line with chip enable low and output enable high
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FA       <= 21'h0;
      FCE_N    <= 1'b1;
      FOE_N    <= 1'b1;
      FWE_N    <= 1'b1;
      FRESET_N <= 1'b0;
      FDQ_O    <= 16'h0;
      FDQ_OE   <= 1'b0;
    end else begin
      FA       <= addr_q;
      FDQ_O    <= flash_dat_q;
      FRESET_N <= (state_q != S_RESET); // RL22
      // Enables rise between every access so each status read gets a fresh snapshot
      FCE_N    <= !(state_q == S_SETUP || state_q == S_STROBE); // RL5
      FOE_N    <= !(state_q == S_STROBE && !is_write_q); // RL20
      FWE_N    <= !(state_q == S_STROBE && is_write_q); // RL20
      FDQ_OE   <= is_write_q && (state_q == S_SETUP || state_q == S_STROBE || state_q == S_HOLD);
    end
  end

  // ****************************************
  // Result capture and status tracking
  // ****************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_q     <= 16'h0;
      status_q    <= 8'h00;
      accum_q     <= 8'h00;
      stat_mode_q <= 1'b0;
      seq_err_q   <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      if (go) done_q <= 1'b0;
      if (state_q == S_HOLD) begin
        done_q <= 1'b1;
        if (!is_write_q) begin
          rdata_q <= dq_val_q;
          if (stat_mode_q || op_q == flash_ctl_pkg::OP_POLL) begin
            // Upper byte should be zero; reserved bit dropped
            status_q  <= usable(dq_val_q[7:0]); // RL3
            // Only the error bits accumulate on the host copy
            accum_q   <= accum_q | (usable(dq_val_q[7:0]) & flash_ctl_pkg::ERROR_MASK); // RL16
            seq_err_q <= (usable(dq_val_q[7:0]) & flash_ctl_pkg::ERROR_MASK) == flash_ctl_pkg::ERROR_MASK; // RL14
          end
        end else begin
          unique case (op_q)
            flash_ctl_pkg::OP_STATUS: stat_mode_q <= 1'b1; // RL1
            flash_ctl_pkg::OP_ARRAY:  stat_mode_q <= 1'b0; // RL2
            flash_ctl_pkg::OP_CLEAR: begin
              accum_q     <= 8'h00; // RL17
              seq_err_q   <= 1'b0;
              stat_mode_q <= 1'b1; // RL18
            end
            default: stat_mode_q <= stat_mode_q;
          endcase
        end
      end
      if (state_q == S_RESET) begin
        status_q    <= 8'h00; // RL19
        accum_q     <= 8'h00;
        seq_err_q   <= 1'b0;
        stat_mode_q <= 1'b0; // RL22
      end
    end
  end

endmodule

// ### sim/flash_dev_model.sv
// Behavioural model of the flash status register and its read paths
`timescale 1ns/1ps
module flash_dev_model (
  // Flash pins
  input  wire logic [20:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  input  wire logic [15:0] dq_in,
  input  wire logic        dq_oe,
  output logic      [15:0] dq_out,
  // Machine updates ordered by the bench
  input  wire logic        load_stb,
  input  wire logic [7:0]  load_val
);
  // Power-on state: machine ready, array reads
  logic [7:0]  sr = 8'h80;
  logic [7:0]  snap;
  logic        stat_mode = 1'b0;
  logic        wr_act;
  logic        drv;
  logic [15:0] val;
  logic [15:0] held;

  // Write ends at the first rise of strobe or chip enable, even when both rise together
  assign wr_act = !ce_n && !we_n && oe_n;
  // Machine sets bits but never clears the error bits; commands latch as a write ends
  always @(negedge reset_n or posedge load_stb or negedge wr_act) begin
    if (!reset_n) begin
      sr        <= 8'h80;
      stat_mode <= 1'b0;
    end else if (load_stb) begin
      sr <= (sr & 8'h3A) | load_val;
    end else if (dq_oe) begin
      case (dq_in[7:0])
        8'h70: stat_mode <= 1'b1;
        // A busy machine takes only status reads
        8'hFF: if (sr[7]) stat_mode <= 1'b0;
        8'h50: if (sr[7]) sr <= sr & 8'hC5;
        default: ;
      endcase
    end
  end
  // Snapshot on the later enable fall, so a moving status never tears
  always @(negedge ce_n or negedge oe_n)
    if (!ce_n && !oe_n) snap <= sr;
  assign drv = !ce_n && !oe_n && we_n && reset_n;
  assign val = stat_mode ? {8'h00, snap} : (addr[15:0] ^ 16'h5AC3);
  // Floating bus shows the inverse of the last value, not a lucky match
  always @* if (drv) held = val;
  assign dq_out = drv ? val : ~held;
endmodule

// ### sim/flash_status_ctl_chk.sv
// Checker of the flash pin sequencing and bus response of the status controller
`timescale 1ns/1ps
module flash_status_ctl_chk (
  // Clock, reset and bus response
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        HRESP,
  input wire logic        HREADYOUT,
  // Flash pins
  input wire logic        FCE_N,
  input wire logic        FOE_N,
  input wire logic        FWE_N,
  input wire logic        FRESET_N,
  input wire logic [15:0] FDQ_O,
  input wire logic        FDQ_OE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // Zero wait states and an okay answer on every cycle
  chk_bus_okay: assert property (!HRESP && HREADYOUT) else $error("bus answer not okay");
  chk_write_ctl: assert property (!FWE_N |-> !FCE_N && FOE_N) else $error("bad write enables");
  chk_write_len: assert property ($fell(FWE_N) |-> ##8 !FWE_N ##1 FWE_N) else $error("write strobe length");
  chk_write_data: assert property (!FWE_N |-> FDQ_OE && $stable(FDQ_O)) else $error("write data moved");
  chk_read_len: assert property ($fell(FOE_N) |-> ##8 !FOE_N ##1 FOE_N) else $error("read strobe length");
  // Chip enable settles four cycles before either strobe
  chk_strobe_setup: assert property ($fell(FOE_N) || $fell(FWE_N) |-> !$past(FCE_N, 4))
    else $error("chip enable setup short");
  chk_read_bus: assert property (!FOE_N |-> !FDQ_OE && FWE_N) else $error("contention on read");
  // Chip enable must drop out for four cycles after every read or write strobe
  chk_ce_release: assert property ($rose(FWE_N) || $rose(FOE_N) |-> ##[1:2] FCE_N [*4])
    else $error("chip enable not released");
  chk_reset_pin: assert property (disable iff (1'b0) RST |=> !FRESET_N && FCE_N && !FDQ_OE)
    else $error("flash not held in reset");
  chk_reset_pulse: assert property ($fell(FRESET_N) |-> !FRESET_N [*8]) else $error("reset pulse short");
endmodule

bind flash_status_ctl flash_status_ctl_chk u_chk (.MCLK, .RST, .HRESP, .HREADYOUT, .FCE_N, .FOE_N, .FWE_N,
  .FRESET_N, .FDQ_O, .FDQ_OE);

// ### sim/testbench.sv
// Self-checking bench for the flash status controller
`timescale 1ns/1ps
module testbench;
  logic        MCLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, load_stb;
  logic        FCE_N, FOE_N, FWE_N, FRESET_N, FDQ_OE;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, r, seed;
  logic [20:0] FA;
  logic [15:0] FDQ_I, FDQ_O;
  logic [7:0]  load_val, exp_sr, exp_acc, old;
  int          errors, n_checks, cyc;

  flash_status_ctl u_dut (.MCLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT),
    .HRDATA, .HREADYOUT, .HRESP, .FA, .FCE_N, .FOE_N, .FWE_N, .FRESET_N, .FDQ_I, .FDQ_O, .FDQ_OE);
  flash_dev_model u_flash (.addr(FA), .ce_n(FCE_N), .oe_n(FOE_N), .we_n(FWE_N), .reset_n(FRESET_N),
    .dq_in(FDQ_O), .dq_oe(FDQ_OE), .dq_out(FDQ_I), .load_stb, .load_val);

  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Status word as the controller should report it, done bit left out
  function automatic logic [31:0] stat_exp(logic [7:0] s, logic m);
    return {20'h0, s[5] & s[4] & s[3] & s[1], m, 2'b00, s & 8'hFE};
  endfunction
  function automatic logic [31:0] arr_exp(logic [20:0] a);
    return {16'h0, a[15:0] ^ 16'h5AC3};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single word transfer; signals held until ready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR  <= {24'h0, a};
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic load(input logic [7:0] v);
    load_val <= v;
    load_stb <= 1'b1;
    @(posedge MCLK);
    load_stb <= 1'b0;
    exp_sr = (exp_sr & 8'h3A) | v;
  endtask
  // Issue one operation, optionally move status mid-strobe, then wait idle
  task automatic op(input logic [2:0] code, input logic ld, input logic [7:0] v);
    bus(1'b1, flash_ctl_pkg::CMD_OFS, {29'h0, code});
    repeat (9) @(posedge MCLK);
    if (ld) load(v);
    do bus(1'b0, flash_ctl_pkg::STAT_OFS, 32'h0); while (rd[8] !== 1'b0);
  endtask
  task automatic poll_check();
    op(flash_ctl_pkg::OP_POLL, 1'b0, 8'h00);
    check(rd & 32'hDFF, stat_exp(exp_sr, 1'b1));
    exp_acc = exp_acc | (exp_sr & 8'h3A);
    bus(1'b0, flash_ctl_pkg::ACCUM_OFS, 32'h0);
    check(rd, {24'h0, exp_acc});
  endtask
  task automatic arr_read(input logic st);
    r = rnd();
    bus(1'b1, flash_ctl_pkg::ADDR_OFS, {11'h0, r[20:0]});
    op(flash_ctl_pkg::OP_READ, 1'b0, 8'h00);
    bus(1'b0, flash_ctl_pkg::RDATA_OFS, 32'h0);
    check(rd, st ? {24'h0, exp_sr} : arr_exp(r[20:0]));
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, far above the roughly one thousand cycles the tests need
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR t=%0t timeout got=%h exp=%h", $time, cyc, 0);
      stop_test();
    end
  end

  initial begin
    {RST, HSEL, HWRITE, load_stb} = 4'b1000;
    {HTRANS, HSIZE, HADDR, HWDATA, load_val} = {2'h0, 3'h2, 72'h0};
    {seed, exp_sr, exp_acc, errors, n_checks, cyc} = {32'h90F884BA, 8'h80, 8'h00, 96'h0};
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    bus(1'b0, flash_ctl_pkg::STAT_OFS, 32'h0);
    check(rd, flash_ctl_pkg::WORD_RST);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    // Plain data write; low byte is no command, so array mode must survive
    r = rnd();
    bus(1'b1, flash_ctl_pkg::WDATA_OFS, {16'h0, r[15:8], 8'h00});
    op(flash_ctl_pkg::OP_WRITE, 1'b0, 8'h00);
    bus(1'b0, flash_ctl_pkg::WDATA_OFS, 32'h0);
    check(rd, {16'h0, r[15:8], 8'h00});
    repeat (3) arr_read(1'b0);
    $display("test reset_and_array done");
    op(flash_ctl_pkg::OP_STATUS, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      load(i == 0 ? 8'h3A : r[7:0]);
      poll_check();
      arr_read(1'b1);
    end
    $display("test status_accumulate done");
    load(8'h00);
    old = exp_sr;
    op(flash_ctl_pkg::OP_POLL, 1'b1, 8'h80);
    check(rd & 32'hDFF, stat_exp(old, 1'b1));
    poll_check();
    $display("test snapshot done");
    op(flash_ctl_pkg::OP_CLEAR, 1'b0, 8'h00);
    exp_sr = exp_sr & 8'hC5;
    exp_acc = 8'h00;
    poll_check();
    op(flash_ctl_pkg::OP_ARRAY, 1'b0, 8'h00);
    arr_read(1'b0);
    bus(1'b0, flash_ctl_pkg::STAT_OFS, 32'h0);
    check({31'h0, rd[10]}, 32'h0);
    $display("test clear_and_array done");
    load(8'h3A);
    op(flash_ctl_pkg::OP_STATUS, 1'b0, 8'h00);
    // Busy machine takes the status command but must ignore read-array
    op(flash_ctl_pkg::OP_ARRAY, 1'b0, 8'h00);
    arr_read(1'b1);
    op(flash_ctl_pkg::OP_PINRST, 1'b0, 8'h00);
    exp_sr = 8'h80;
    arr_read(1'b0);
    op(flash_ctl_pkg::OP_STATUS, 1'b0, 8'h00);
    op(flash_ctl_pkg::OP_POLL, 1'b0, 8'h00);
    check(rd & 32'hDFF, stat_exp(8'h80, 1'b1));
    $display("test pin_reset done");
    stop_test();
  end
endmodule
